// ### logic/servo_cmd_defs.svh
`ifndef SERVO_CMD_DEFS_SVH
`define SERVO_CMD_DEFS_SVH
`define OFS_CMD 32'h0000_0000
`define OFS_WDATA 32'h0000_0004
`define OFS_CTRL 32'h0000_0008
`define OFS_RESP0 32'h0000_000C
`define OFS_RESP1 32'h0000_0010
`define OFS_RESP2 32'h0000_0014
`define OFS_RESP3 32'h0000_0018
`define OFS_GROUP 32'h0000_001C
`define CTRL_GO_BIT 0
`define CMD_CODE_LSB 8
`define CMD_STAT_RD 8'h01
`define CMD_STAT_CLR 8'h81
`define CMD_GRP_WR 8'h85
`define CMD_GRP_RD 8'h04
`define CMD_PAR_WR 8'h94
`define DNO_ZERO 8'h00
`define DNO_GRP_RD 8'h01
`define CLR_KEY 16'h1EA5
`define GRP_MAX 32'h0000_0005
`define GRP_RST 3'h0
`define DP_HI 27
`define DP_LO 24
`define DP_NONE 4'h0
`define DP_MAX 4'h5
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// ### logic/servo_cmd_pkg.sv
package servo_cmd_pkg;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_NAME = 3'b001,
    OP_DATA = 3'b010,
    OP_CLR = 3'b011,
    OP_GRP_WR = 3'b100,
    OP_GRP_RD = 3'b101,
    OP_PAR_WR = 3'b110
  } op_e;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } state_e;
  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;
  typedef struct packed {
    logic wr;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } reg_wr_s;
  typedef struct packed {
    logic aw_ok;
    logic w_ok;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_state_s;
  typedef struct packed {
    state_e st;
    logic [7:0] cmd;
    logic [7:0] dno;
    logic [31:0] wdata;
    logic done;
    logic err;
    logic [3:0][31:0] resp;
    logic [2:0] grp;
    logic last_ok;
    logic [4:0] last_item;
    logic [4:0] sel;
    logic clr_p;
    logic [4:0] clr_sel;
    logic par_p;
    logic [31:0] par_wdata;
  } top_state_s;
endpackage

// ### logic/cmd_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "servo_cmd_defs.svh"
module cmd_decode
  import servo_cmd_pkg::*;
(
  // Command and data number
  input wire logic [7:0] cmd_i,
  input wire logic [7:0] dno_i,
  // Decoded operation
  output var op_e op_o,
  output var logic [4:0] item_o
);
  logic [3:0] hi;
  logic [3:0] lo;
  logic item_ok;

  assign hi = dno_i[7:4];
  assign lo = dno_i[3:0];
  // Name and data items share one index; bit 7 picks data over name
  assign item_o = {dno_i[5], lo};
  assign item_ok = (((hi == 4'h0) || (hi == 4'h8)) && (lo <= 4'hE)) ||
                   (((hi == 4'h2) || (hi == 4'hA)) && (lo <= 4'h9));

  always_comb
  begin
    op_o = OP_NONE;
    case (cmd_i)
      `CMD_STAT_RD: op_o = item_ok ? (dno_i[7] ? OP_DATA : OP_NAME) : OP_NONE;
      `CMD_STAT_CLR: op_o = (dno_i == `DNO_ZERO) ? OP_CLR : OP_NONE;
      `CMD_GRP_WR: op_o = (dno_i == `DNO_ZERO) ? OP_GRP_WR : OP_NONE;
      `CMD_GRP_RD: op_o = (dno_i == `DNO_GRP_RD) ? OP_GRP_RD : OP_NONE;
      `CMD_PAR_WR: op_o = (dno_i != `DNO_ZERO) ? OP_PAR_WR : OP_NONE;
      default: op_o = OP_NONE;
    endcase
  end
endmodule
`default_nettype wire

// ### logic/axil_slave.sv
`timescale 1ns/100ps
`default_nettype none
`include "servo_cmd_defs.svh"
module axil_slave
  import servo_cmd_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Bus side
  input wire axil_req_s req_i,
  output var axil_rsp_s rsp_o,
  // Register side
  output var reg_wr_s wr_o,
  input wire logic wr_err_i,
  output var logic [31:0] rd_addr_o,
  input wire logic [31:0] rdata_i,
  input wire logic rd_err_i
);
  axil_state_s s_reg;
  axil_state_s s_next;

  // Address and data are held apart so either may arrive first
  always_comb
  begin
    s_next = s_reg;
    if (ce_i)
    begin
      if (req_i.awvalid && rsp_o.awready)
      begin
        s_next.aw_ok = 1'b1;
        s_next.awaddr = req_i.awaddr;
      end
      if (req_i.wvalid && rsp_o.wready)
      begin
        s_next.w_ok = 1'b1;
        s_next.wdata = req_i.wdata;
        s_next.wstrb = req_i.wstrb;
      end
      if (s_reg.aw_ok && s_reg.w_ok)
      begin
        s_next.aw_ok = 1'b0;
        s_next.w_ok = 1'b0;
        s_next.bvalid = 1'b1;
        s_next.bresp = wr_err_i ? `RESP_DECERR : `RESP_OKAY;
      end
      if (s_reg.bvalid && req_i.bready)
        s_next.bvalid = 1'b0;
      if (req_i.arvalid && rsp_o.arready)
      begin
        s_next.rvalid = 1'b1;
        s_next.rdata = rdata_i;
        s_next.rresp = rd_err_i ? `RESP_DECERR : `RESP_OKAY;
      end
      else if (s_reg.rvalid && req_i.rready)
        s_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign rsp_o.awready = ce_i && !s_reg.aw_ok && !s_reg.bvalid;
  assign rsp_o.wready = ce_i && !s_reg.w_ok && !s_reg.bvalid;
  assign rsp_o.bvalid = s_reg.bvalid;
  assign rsp_o.bresp = s_reg.bresp;
  assign rsp_o.arready = ce_i && !s_reg.rvalid;
  assign rsp_o.rvalid = s_reg.rvalid;
  assign rsp_o.rdata = s_reg.rdata;
  assign rsp_o.rresp = s_reg.rresp;
  assign rd_addr_o = req_i.araddr;
  assign wr_o.wr = ce_i && s_reg.aw_ok && s_reg.w_ok;
  assign wr_o.addr = s_reg.awaddr;
  assign wr_o.data = s_reg.wdata;
  assign wr_o.strb = s_reg.wstrb;
endmodule
`default_nettype wire

// ### logic/servo_cmd_top.sv
// Operation
// - Every taken command ends with an answer
// - Point position counts from least digit
// - Decimal write without point position refused
// - Name and unit read items accepted
// - Name nine chars, unit five chars returned
// - Status data read returns value and format
// - Clear key zeroes last read item
// - Group select stores codes zero to five
// - Group read returns selected group code
// - Parameter number is data number in group
`timescale 1ns/100ps
`default_nettype none
`include "servo_cmd_defs.svh"
module servo_cmd_top
  import servo_cmd_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Register bus
  input wire axil_req_s axil_req_i,
  output var axil_rsp_s axil_rsp_o,
  // Status display items
  output var logic [4:0] stat_sel_o,
  input wire logic [31:0] stat_value_i,
  input wire logic [3:0] stat_dp_i,
  input wire logic stat_hex_i,
  input wire logic [111:0] stat_text_i,
  output var logic stat_clr_o,
  output var logic [4:0] stat_clr_sel_o,
  // Parameter store
  output var logic [2:0] par_group_o,
  output var logic [7:0] par_num_o,
  input wire logic par_dec_i,
  output var logic par_wr_o,
  output var logic [31:0] par_wdata_o
);
  top_state_s s_reg;
  top_state_s s_next;
  reg_wr_s wr;
  logic wr_err;
  logic [31:0] rd_addr;
  logic [31:0] rdata;
  logic rd_err;
  op_e op;
  logic [4:0] item;
  op_e new_op;
  logic [4:0] new_item;
  logic go;
  logic [3:0] wdp;
  logic [31:0] cmd_word;
  logic [15:0] cmd_next;

  // ------------------------------------------------------------
  // Bus front end and decoders
  // ------------------------------------------------------------
  axil_slave u_bus (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .req_i(axil_req_i),
    .rsp_o(axil_rsp_o),
    .wr_o(wr),
    .wr_err_i(wr_err),
    .rd_addr_o(rd_addr),
    .rdata_i(rdata),
    .rd_err_i(rd_err)
  );

  cmd_decode u_dec (
    .cmd_i(s_reg.cmd),
    .dno_i(s_reg.dno),
    .op_o(op),
    .item_o(item)
  );

  // Decodes the word being written so the item select is ready before
  // execution, which keeps the status source a pure lookup
  cmd_decode u_dec_new (
    .cmd_i(cmd_next[15:8]),
    .dno_i(cmd_next[7:0]),
    .op_o(new_op),
    .item_o(new_item)
  );

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  always_comb
  begin
    wr_err = 1'b0;
    case (wr.addr)
      `OFS_CMD, `OFS_WDATA, `OFS_CTRL: wr_err = 1'b0;
      `OFS_RESP0, `OFS_RESP1, `OFS_RESP2, `OFS_RESP3, `OFS_GROUP: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  always_comb
  begin
    rdata = 32'h0000_0000;
    rd_err = 1'b0;
    case (rd_addr)
      `OFS_CMD: rdata = {16'h0000, s_reg.cmd, s_reg.dno};
      `OFS_WDATA: rdata = s_reg.wdata;
      `OFS_CTRL: rdata = {29'h0000_0000, s_reg.err, s_reg.done, s_reg.st == ST_EXEC};
      `OFS_RESP0: rdata = s_reg.resp[0];
      `OFS_RESP1: rdata = s_reg.resp[1];
      `OFS_RESP2: rdata = s_reg.resp[2];
      `OFS_RESP3: rdata = s_reg.resp[3];
      `OFS_GROUP: rdata = {29'h0000_0000, s_reg.grp};
      default: rd_err = 1'b1;
    endcase
  end

  // Go is taken only when idle; a start during execution is dropped
  assign go = wr.wr && (wr.addr == `OFS_CTRL) && wr.strb[0] &&
              wr.data[`CTRL_GO_BIT] && (s_reg.st == ST_IDLE);
  assign wdp = s_reg.wdata[`DP_HI:`DP_LO];
  // Next command word built apart from s_next, so the select decode forms no loop
  assign cmd_word = merge({16'h0000, s_reg.cmd, s_reg.dno}, wr.data, wr.strb);
  assign cmd_next = (wr.wr && (wr.addr == `OFS_CMD)) ? cmd_word[15:0] : {s_reg.cmd, s_reg.dno};

  // ------------------------------------------------------------
  // Command execution
  // ------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    if (ce_i)
    begin
      s_next.clr_p = 1'b0;
      s_next.par_p = 1'b0;
      if (wr.wr && (wr.addr == `OFS_CMD))
      begin
        s_next.cmd = cmd_word[15:8];
        s_next.dno = cmd_word[7:0];
      end
      if (wr.wr && (wr.addr == `OFS_WDATA))
        s_next.wdata = merge(s_reg.wdata, wr.data, wr.strb);
      if ((new_op == OP_NAME) || (new_op == OP_DATA))
        s_next.sel = new_item;
      if (go)
      begin
        s_next.st = ST_EXEC;
        s_next.done = 1'b0;
        s_next.err = 1'b0;
      end
      case (s_reg.st)
        ST_IDLE: s_next.st = s_next.st;
        ST_EXEC:
        begin
          s_next.st = ST_IDLE;
          s_next.done = 1'b1;
          s_next.last_ok = 1'b0;
          case (op)
            OP_NAME:
            begin
              s_next.resp[0] = stat_text_i[31:0];
              s_next.resp[1] = stat_text_i[63:32];
              s_next.resp[2] = stat_text_i[95:64];
              s_next.resp[3] = {16'h0000, stat_text_i[111:96]};
            end
            OP_DATA:
            begin
              s_next.resp[0] = stat_value_i;
              s_next.resp[1] = {20'h0_0000, 3'h0, stat_hex_i, 4'h0, stat_dp_i};
              s_next.resp[2] = 32'h0000_0000;
              s_next.resp[3] = 32'h0000_0000;
              s_next.last_ok = 1'b1;
              s_next.last_item = item;
            end
            OP_CLR:
            begin
              // Needs the read directly before it, so a stray clear cannot
              // wipe an item software never looked at
              if (s_reg.last_ok && (s_reg.wdata[15:0] == `CLR_KEY))
              begin
                s_next.clr_p = 1'b1;
                s_next.clr_sel = s_reg.last_item;
              end
              else
                s_next.err = 1'b1;
            end
            OP_GRP_WR:
            begin
              if (s_reg.wdata <= `GRP_MAX)
                s_next.grp = s_reg.wdata[2:0];
              else
                s_next.err = 1'b1;
            end
            OP_GRP_RD: s_next.resp[0] = {29'h0000_0000, s_reg.grp};
            OP_PAR_WR:
            begin
              if (par_dec_i && ((wdp == `DP_NONE) || (wdp > `DP_MAX)))
                s_next.err = 1'b1;
              else
              begin
                s_next.par_p = 1'b1;
                s_next.par_wdata = s_reg.wdata;
              end
            end
            default: s_next.err = 1'b1;
          endcase
        end
        default: s_next.st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_reg <= '0;
      s_reg.grp <= `GRP_RST;
    end
    else
      s_reg <= s_next;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign stat_sel_o = s_reg.sel;
  assign stat_clr_o = s_reg.clr_p && ce_i;
  assign stat_clr_sel_o = s_reg.clr_sel;
  assign par_group_o = s_reg.grp;
  assign par_num_o = s_reg.dno;
  assign par_wr_o = s_reg.par_p && ce_i;
  assign par_wdata_o = s_reg.par_wdata;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence go_s;
    ce_i && go;
  endsequence

  sequence exec_s;
    ce_i && (s_reg.st == ST_EXEC);
  endsequence

  property go_done_p;
    go_s ##1 exec_s |=> s_reg.done && (s_reg.st == ST_IDLE);
  endproperty

  go_to_done_a: assert property (go_done_p)
    else $error("command not answered");

  go_clears_a: assert property (go_s |=> !s_reg.done && (s_reg.st == ST_EXEC))
    else $error("start did not enter execution");

  grp_set_a: assert property (exec_s and (op == OP_GRP_WR) && (s_reg.wdata <= `GRP_MAX)
    |=> (s_reg.grp == $past(s_reg.wdata[2:0])) && !s_reg.err)
    else $error("group not stored");

  grp_bad_a: assert property (exec_s and (op == OP_GRP_WR) && (s_reg.wdata > `GRP_MAX)
    |=> s_reg.err && $stable(s_reg.grp))
    else $error("bad group accepted");

  grp_hold_a: assert property (!((s_reg.st == ST_EXEC) && (op == OP_GRP_WR))
    |=> $stable(s_reg.grp))
    else $error("group changed without selection");

  grp_read_a: assert property (exec_s and (op == OP_GRP_RD)
    |=> s_reg.resp[0] == {29'h0000_0000, $past(s_reg.grp)})
    else $error("group readback wrong");

  dp_refuse_a: assert property (exec_s and (op == OP_PAR_WR) && par_dec_i && (wdp == `DP_NONE)
    |=> s_reg.err && !s_reg.par_p)
    else $error("write without point position stored");

  clr_cause_a: assert property (s_reg.clr_p && $past(ce_i)
    |-> $past((op == OP_CLR) && s_reg.last_ok && (s_reg.wdata[15:0] == `CLR_KEY)))
    else $error("clear without key after read");

  data_read_a: assert property (exec_s and (op == OP_DATA)
    |=> (s_reg.resp[0] == $past(stat_value_i)) && s_reg.last_ok)
    else $error("status data not returned");

  name_read_a: assert property (exec_s and (op == OP_NAME)
    |=> (s_reg.resp[3][15:0] == $past(stat_text_i[111:96])) && !s_reg.last_ok)
    else $error("name and unit not returned");
endmodule
`default_nettype wire

// ### test/servo_stat_model.sv
`timescale 1ns/100ps
`default_nettype none
module servo_stat_model
(
  // Clock
  input wire logic clk_i,
  // Status items
  input wire logic [4:0] stat_sel_i,
  output logic [31:0] stat_value_o,
  output logic [3:0] stat_dp_o,
  output logic stat_hex_o,
  output logic [111:0] stat_text_o,
  input wire logic stat_clr_i,
  input wire logic [4:0] stat_clr_sel_i,
  // Parameter store
  input wire logic [2:0] par_group_i,
  input wire logic [7:0] par_num_i,
  output logic par_dec_o,
  input wire logic par_wr_i,
  input wire logic [31:0] par_wdata_i
);
  // ----------------------------------------
  // Item table and parameter store
  // ----------------------------------------
  logic [31:0] cleared_reg = 32'h0;
  logic [31:0] wr_data_reg = 32'h0;
  logic [10:0] wr_addr_reg = 11'h0;
  int wr_cnt = 0;
  // Values derive from the index, so a wrong select shows at once
  assign stat_value_o = cleared_reg[stat_sel_i] ? 32'h0 : {16'h00C3, 11'h0, stat_sel_i};
  assign stat_dp_o = {1'b0, stat_sel_i[2:0]};
  assign stat_hex_o = stat_sel_i[4];
  assign stat_text_o = {14{3'h0, stat_sel_i}};
  // Odd parameter numbers are decimal-handled
  assign par_dec_o = par_num_i[0];
  always @(posedge clk_i)
  begin
    if (stat_clr_i) cleared_reg[stat_clr_sel_i] <= 1'b1;
    if (par_wr_i)
    begin
      wr_data_reg <= par_wdata_i;
      wr_addr_reg <= {par_group_i, par_num_i};
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ### test/servo_cmd_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "servo_cmd_defs.svh"
module servo_cmd_top_tb;
  import servo_cmd_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce = 1'b1;
  axil_req_s req = '0;
  axil_rsp_s rsp;
  logic [4:0] stat_sel_o;
  logic [31:0] stat_value_i;
  logic [3:0] stat_dp_i;
  logic stat_hex_i;
  logic [111:0] stat_text_i;
  logic stat_clr_o;
  logic [4:0] stat_clr_sel_o;
  logic [2:0] par_group_o;
  logic [7:0] par_num_o;
  logic par_dec_i;
  logic par_wr_o;
  logic [31:0] par_wdata_o;
  int error_cnt = 0;
  int total_checks = 0;
  always #25 clk_i = ~clk_i;
  servo_cmd_top i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce), .axil_req_i(req),
    .axil_rsp_o(rsp), .stat_sel_o(stat_sel_o), .stat_value_i(stat_value_i),
    .stat_dp_i(stat_dp_i), .stat_hex_i(stat_hex_i), .stat_text_i(stat_text_i),
    .stat_clr_o(stat_clr_o), .stat_clr_sel_o(stat_clr_sel_o), .par_group_o(par_group_o),
    .par_num_o(par_num_o), .par_dec_i(par_dec_i), .par_wr_o(par_wr_o),
    .par_wdata_o(par_wdata_o));
  servo_stat_model i_model (.clk_i(clk_i), .stat_sel_i(stat_sel_o),
    .stat_value_o(stat_value_i), .stat_dp_o(stat_dp_i), .stat_hex_o(stat_hex_i),
    .stat_text_o(stat_text_i), .stat_clr_i(stat_clr_o), .stat_clr_sel_i(stat_clr_sel_o),
    .par_group_i(par_group_o), .par_num_i(par_num_o), .par_dec_o(par_dec_i),
    .par_wr_i(par_wr_o), .par_wdata_i(par_wdata_o));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_sim();
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic hang();
    error_cnt++;
    end_sim();
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Sampling at the falling edge avoids racing the slave's own updates
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah;
    logic wh;
    logic bh;
    int n;
    @(posedge clk_i);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge clk_i);
      ah = req.awvalid & rsp.awready;
      wh = req.wvalid & rsp.wready;
      bh = rsp.bvalid;
      r = rsp.bresp;
      @(posedge clk_i);
      if (ah) req.awvalid <= 1'b0;
      if (wh) req.wvalid <= 1'b0;
      if (bh) break;
    end
    req.bready <= 1'b0;
    if (n == 40) hang();
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
    logic ah;
    logic bh;
    int n;
    @(posedge clk_i);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge clk_i);
      ah = req.arvalid & rsp.arready;
      bh = rsp.rvalid;
      v = rsp.rdata;
      r = rsp.rresp;
      @(posedge clk_i);
      if (ah) req.arvalid <= 1'b0;
      if (bh) break;
    end
    req.rready <= 1'b0;
    if (n == 40) hang();
  endtask
  task automatic cmd_run(input logic [7:0] c, input logic [7:0] dn, input logic [31:0] d,
      output logic e);
    logic [31:0] s;
    logic [1:0] r;
    int k;
    axi_wr(`OFS_CMD, {16'h0, c, dn}, r);
    axi_wr(`OFS_WDATA, d, r);
    axi_wr(`OFS_CTRL, 32'h1, r);
    s = 32'h0;
    for (k = 0; k < 20 && s[1] !== 1'b1; k++) axi_rd(`OFS_CTRL, s, r);
    e = s[2];
    if (s[1] !== 1'b1) hang();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_group();
    logic e;
    logic [31:0] v;
    logic [1:0] r;
    int g;
    axi_rd(`OFS_GROUP, v, r);
    chk("group after reset", v, 32'h0);
    for (g = 0; g < 6; g++)
    begin
      cmd_run(`CMD_GRP_WR, `DNO_ZERO, g, e);
      chk("group err", e, 0);
      chk("group out", par_group_o, g);
      cmd_run(`CMD_GRP_RD, `DNO_GRP_RD, 32'h0, e);
      axi_rd(`OFS_RESP0, v, r);
      chk("group read", v[2:0], g);
    end
    cmd_run(`CMD_GRP_WR, `DNO_ZERO, 32'h6, e);
    chk("group bad err", e, 1);
    axi_rd(`OFS_GROUP, v, r);
    chk("group kept", v, 32'h5);
    @(posedge clk_i);
    ce <= 1'b0;
    @(negedge clk_i);
    chk("frozen bus", {rsp.awready, rsp.arready, par_group_o}, {2'b00, 3'h5});
    @(posedge clk_i);
    ce <= 1'b1;
  endtask
  task automatic t_items(input logic [7:0] c0, input bit dat);
    logic [7:0] dn [6];
    logic e;
    logic [31:0] v;
    logic [1:0] r;
    logic [4:0] s;
    int i;
    int j;
    dn = '{c0, c0 | 8'h0E, c0 | 8'h20, c0 | 8'h29, c0 | 8'h0F, c0 | 8'h2A};
    for (i = 0; i < 6; i++)
    begin
      cmd_run(`CMD_STAT_RD, dn[i], 32'h0, e);
      chk("item err", e, i > 3);
      s = {dn[i][5], dn[i][3:0]};
      for (j = 0; j < 4 && i < 4; j++)
      begin
        axi_rd(`OFS_RESP0 + 4 * j, v, r);
        if (dat && j == 0) chk("data value", v, {16'h00C3, 11'h0, s});
        if (dat && j == 1) chk("data format", {v[8], v[3:0]}, {s[4], 1'b0, s[2:0]});
        if (!dat) chk("name unit", j == 3 ? v[15:0] : v, {4{3'h0, s}} & {{16{j < 3}}, 16'hFFFF});
      end
    end
  endtask
  task automatic t_clear();
    logic e;
    logic [31:0] v;
    logic [1:0] r;
    cmd_run(`CMD_STAT_RD, 8'h85, 32'h0, e);
    cmd_run(`CMD_STAT_CLR, `DNO_ZERO, {16'h0, `CLR_KEY}, e);
    chk("clear err", e, 0);
    chk("clear item", i_model.cleared_reg, 32'h20);
    cmd_run(`CMD_STAT_RD, 8'h85, 32'h0, e);
    axi_rd(`OFS_RESP0, v, r);
    chk("cleared value", v, 32'h0);
    cmd_run(`CMD_STAT_RD, 8'h86, 32'h0, e);
    cmd_run(`CMD_STAT_CLR, `DNO_ZERO, 32'h1EA4, e);
    chk("bad key err", e, 1);
    cmd_run(`CMD_STAT_RD, 8'h86, 32'h0, e);
    cmd_run(`CMD_GRP_RD, `DNO_GRP_RD, 32'h0, e);
    cmd_run(`CMD_STAT_CLR, `DNO_ZERO, {16'h0, `CLR_KEY}, e);
    chk("late clear err", e, 1);
    chk("nothing cleared", i_model.cleared_reg, 32'h20);
  endtask
  task automatic t_param();
    logic e;
    cmd_run(`CMD_GRP_WR, `DNO_ZERO, 32'h3, e);
    cmd_run(`CMD_PAR_WR, 8'h11, 32'h0200009B, e);
    chk("dec write err", e, 0);
    chk("dec write data", i_model.wr_data_reg, 32'h0200009B);
    chk("write target", i_model.wr_addr_reg, {3'h3, 8'h11});
    cmd_run(`CMD_PAR_WR, 8'h11, 32'h0000009B, e);
    chk("no point err", e, 1);
    cmd_run(`CMD_PAR_WR, 8'h11, 32'h0600009B, e);
    chk("bad point err", e, 1);
    chk("refused not stored", i_model.wr_cnt, 1);
    cmd_run(`CMD_PAR_WR, 8'h12, 32'h0000ABCD, e);
    chk("hex write", i_model.wr_data_reg, 32'h0000ABCD);
  endtask
  task automatic t_refuse();
    logic e;
    logic [31:0] v;
    logic [1:0] r;
    axi_rd(32'h40, v, r);
    chk("unmapped read resp", r, `RESP_DECERR);
    chk("unmapped read data", v, 32'h0);
    axi_wr(32'h40, 32'h1, r);
    chk("unmapped write", r, `RESP_DECERR);
    cmd_run(8'h77, `DNO_ZERO, 32'h0, e);
    chk("unknown cmd err", e, 1);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    t_group();
    t_items(8'h00, 1'b0);
    t_items(8'h80, 1'b1);
    t_clear();
    t_param();
    t_refuse();
    end_sim();
  end
endmodule
`default_nettype wire
